// ---- design/swsf_pkg.sv ----
// What this block does
// - master releases write-one before its low limit
// - master holds write-zero low past minimum time
// - master keeps low windows firmly low
// - recovery after rise before next slot
// - read slot opens like write-one, short low
// - slave zero: pull low, timed release
// - slave one: never drives the line
// - master samples inside its sampling window
// - master keeps read low short, samples late
// - master waits full slot before next
// - recovery lengthened for many slaves
// - falling edge filtered at both speeds: 500 ns standard, 100 ns fast
// - short negative glitches ignored at any speed
// - glitches ignored during rising-edge hold-off
// - low lasting past hold-off starts slot
// - identification code carries its crc8 on top
// - master checks crc8 over first 56 bits
// - crc8 byte sent in true form
// - crc16 over exchanged data, both ends
// - falling edge starts slave slot timer
// - only the master opens slots
// - standard timing unless fast speed set
package swsf_pkg;
  localparam int CLK_NS = 50;
  localparam int TW = 12;
  typedef logic [TW-1:0] swsf_cnt_t;

  function automatic int cyc_up(input int ns);
    return (ns + CLK_NS - 1) / CLK_NS;
  endfunction
  function automatic int cyc_dn(input int ns);
    return (ns / CLK_NS < 1) ? 1 : ns / CLK_NS;
  endfunction

  // times in ns, standard and fast speed
  localparam int W1L_STD_NS = 6000;
  localparam int W1L_OD_NS = 1000;
  localparam int W0L_STD_NS = 70000;
  localparam int W0L_OD_NS = 8000;
  localparam int RL_STD_NS = 6000;
  localparam int RL_OD_NS = 1000;
  localparam int MSR_STD_NS = 13000;
  localparam int MSR_OD_NS = 2000;
  localparam int SLOT_STD_NS = 80000;
  localparam int SLOT_OD_NS = 10000;
  localparam int REC_STD_NS = 5000;
  localparam int REC_OD_NS = 2000;
  localparam int SAMP_STD_NS = 30000;
  localparam int SAMP_OD_NS = 4000;
  localparam int PULL_STD_NS = 30000;
  localparam int PULL_OD_NS = 4000;
  localparam int HOLD_STD_NS = 2000;
  localparam int HOLD_OD_NS = 500;
  localparam int FILT_STD_NS = 500;
  localparam int HYS_NS = 100;

  localparam swsf_cnt_t W1L_STD = TW'(cyc_dn(W1L_STD_NS));
  localparam swsf_cnt_t W1L_OD = TW'(cyc_dn(W1L_OD_NS));
  localparam swsf_cnt_t W0L_STD = TW'(cyc_up(W0L_STD_NS));
  localparam swsf_cnt_t W0L_OD = TW'(cyc_up(W0L_OD_NS));
  localparam swsf_cnt_t RL_STD = TW'(cyc_up(RL_STD_NS));
  localparam swsf_cnt_t RL_OD = TW'(cyc_up(RL_OD_NS));
  localparam swsf_cnt_t MSR_STD = TW'(cyc_dn(MSR_STD_NS));
  localparam swsf_cnt_t MSR_OD = TW'(cyc_dn(MSR_OD_NS));
  localparam swsf_cnt_t SLOT_STD = TW'(cyc_up(SLOT_STD_NS));
  localparam swsf_cnt_t SLOT_OD = TW'(cyc_up(SLOT_OD_NS));
  localparam swsf_cnt_t REC_STD = TW'(cyc_up(REC_STD_NS));
  localparam swsf_cnt_t REC_OD = TW'(cyc_up(REC_OD_NS));
  localparam swsf_cnt_t SAMP_STD = TW'(cyc_up(SAMP_STD_NS));
  localparam swsf_cnt_t SAMP_OD = TW'(cyc_up(SAMP_OD_NS));
  localparam swsf_cnt_t PULL_STD = TW'(cyc_up(PULL_STD_NS));
  localparam swsf_cnt_t PULL_OD = TW'(cyc_up(PULL_OD_NS));
  localparam swsf_cnt_t HOLD_STD = TW'(cyc_up(HOLD_STD_NS));
  localparam swsf_cnt_t HOLD_OD = TW'(cyc_up(HOLD_OD_NS));
  localparam swsf_cnt_t FILT_STD = TW'(cyc_up(FILT_STD_NS));
  localparam swsf_cnt_t HYS_CYC = TW'(cyc_up(HYS_NS));

  // x^8+x^5+x^4+1, bit reversed for lsb-first shifting
  localparam logic [7:0] CRC8_POLY_REFL = 8'h8c;
  localparam logic [15:0] CRC16_POLY_REFL = 16'ha001;
  localparam int ID_DATA_BITS = 56;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] ID_LAST_BYTE = 3'h7;

  function automatic swsf_cnt_t pick(input logic fast, input swsf_cnt_t s, input swsf_cnt_t f);
    return fast ? f : s;
  endfunction

  function automatic logic [7:0] crc8_byte(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC8_POLY_REFL) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC16_POLY_REFL) : (r >> 1);
    end
    return r;
  endfunction
endpackage

// ---- design/swsf_if.sv ----
interface swsf_if;
  logic m_oe;
  logic s_oe;
  logic line;
  // wired-and with pullup: high unless someone drives
  assign line = ~(m_oe | s_oe);
  modport master (output m_oe, input line);
  modport slave (output s_oe, input line);
endinterface

// ---- design/swsf_slave.sv ----
module swsf_slave #(
  parameter logic [55:0] ID_DATA = 56'h00_0000_0000_0001 // arbitrary value
) (
  input wire logic clock, // 20 MHz
  input wire logic rst_n, // async, active low
  swsf_if.slave bus, // single-wire line
  input wire logic fast_speed_flag, // fast timing
  input wire logic rd_mode, // next slots are read slots
  input wire logic tx_load, // pulse: load tx byte, restart bit count
  input wire logic [7:0] tx_data, // byte returned lsb first
  output logic tx_done, // pulse: 8 read slots done
  output logic rx_valid, // pulse: byte written by master
  output logic [7:0] rx_data, // written byte
  output logic [15:0] crc16, // running crc over exchanged bytes
  input wire logic crc_clr, // clears crc16
  output logic [63:0] id_code // crc8 in top byte
);
  import swsf_pkg::*;
  typedef enum logic [1:0] {
    D_IDLE = 2'b00,
    D_FILT = 2'b01,
    D_SLOT = 2'b10,
    D_HOLD = 2'b11
  } swsf_dst_e;

  swsf_dst_e st_r;
  swsf_cnt_t tmr_r;
  logic ln_s1_r, ln_r;
  logic s_oe_r, slot_rd_r, wbit_r;
  logic [2:0] bit_r;
  logic [7:0] tx_sr_r, rx_sr_r;
  logic filt_ok, slot_end;
  swsf_cnt_t filt_need, pull_t, samp_t, hold_t;

  assign bus.s_oe = s_oe_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ln_s1_r <= 1'b1;
      ln_r <= 1'b1;
    end else begin
      ln_s1_r <= bus.line;
      ln_r <= ln_s1_r;
    end
  end

  always_comb begin
    filt_need = fast_speed_flag ? HYS_CYC : FILT_STD;
    pull_t = pick(fast_speed_flag, PULL_STD, PULL_OD);
    samp_t = pick(fast_speed_flag, SAMP_STD, SAMP_OD);
    hold_t = pick(fast_speed_flag, HOLD_STD, HOLD_OD);
    filt_ok = (st_r == D_FILT) && !ln_r && (tmr_r >= filt_need);
    slot_end = (st_r == D_SLOT) && (tmr_r >= pull_t) && (tmr_r > samp_t) && ln_r;
  end

  // slot timer runs from the first low sample, filter time included
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= D_IDLE;
      tmr_r <= '0;
    end else begin
      case (st_r)
        D_IDLE: begin
          if (!ln_r) begin
            st_r <= D_FILT;
            tmr_r <= swsf_cnt_t'(1);
          end
        end
        D_FILT: begin
          tmr_r <= tmr_r + 1'b1;
          if (ln_r) begin
            st_r <= D_IDLE;
          end else if (filt_ok) begin
            st_r <= D_SLOT;
          end
        end
        D_SLOT: begin
          tmr_r <= slot_end ? '0 : tmr_r + 1'b1;
          if (slot_end) begin
            st_r <= D_HOLD;
          end
        end
        default: begin
          tmr_r <= tmr_r + 1'b1;
          if (tmr_r >= hold_t) begin
            // low still present after hold-off enters the filter as a new fall
            st_r <= ln_r ? D_IDLE : D_FILT;
            tmr_r <= swsf_cnt_t'(1);
          end
        end
      endcase
    end
  end

  // pulldown only for a zero; a one leaves the line alone
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_oe_r <= 1'b0;
      slot_rd_r <= 1'b0;
    end else if (filt_ok) begin
      slot_rd_r <= rd_mode;
      s_oe_r <= rd_mode && !tx_sr_r[bit_r];
    end else if (st_r != D_SLOT || tmr_r >= pull_t) begin
      s_oe_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wbit_r <= 1'b1;
    end else if (st_r == D_SLOT && tmr_r == samp_t) begin
      wbit_r <= ln_r;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bit_r <= '0;
      tx_sr_r <= '1;
      rx_sr_r <= '0;
      rx_data <= '0;
      rx_valid <= 1'b0;
      tx_done <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      tx_done <= 1'b0;
      if (tx_load) begin
        tx_sr_r <= tx_data;
        bit_r <= '0;
      end else if (slot_end) begin
        bit_r <= bit_r + 1'b1;
        if (!slot_rd_r) begin
          rx_sr_r <= {wbit_r, rx_sr_r[7:1]};
        end
        if (bit_r == LAST_BIT) begin
          rx_valid <= !slot_rd_r;
          tx_done <= slot_rd_r;
          rx_data <= {wbit_r, rx_sr_r[7:1]};
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      crc16 <= '0;
    end else if (crc_clr) begin
      crc16 <= '0;
    end else if (slot_end && bit_r == LAST_BIT && !tx_load) begin
      crc16 <= crc16_byte(crc16, slot_rd_r ? tx_sr_r : {wbit_r, rx_sr_r[7:1]});
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      id_code <= '0;
    end else begin
      id_code <= {crc8_byte(crc8_byte(crc8_byte(crc8_byte(crc8_byte(crc8_byte(crc8_byte(
        8'h00, ID_DATA[7:0]), ID_DATA[15:8]), ID_DATA[23:16]), ID_DATA[31:24]),
        ID_DATA[39:32]), ID_DATA[47:40]), ID_DATA[55:48]), ID_DATA};
    end
  end
endmodule

// ---- design/swsf_master.sv ----
module swsf_fifo #(
  parameter int W = 9,
  parameter int D = 8
) (
  input wire logic clock, // system clock
  input wire logic rst_n, // async, active low
  input wire logic in_valid, // write request
  output logic in_ready, // not full
  input wire logic [W-1:0] in_data, // write word
  output logic out_valid, // not empty
  input wire logic out_ready, // drain request
  output logic [W-1:0] out_data // head word
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0] cnt_r;
  logic push, pop;

  assign in_ready = (cnt_r != (AW+1)'(D));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module swsf_master #(
  parameter int FIFO_DEPTH = 8,
  parameter int REC_EXTRA = 0 // added recovery cycles for many slaves
) (
  input wire logic clock, // 20 MHz
  input wire logic rst_n, // async, active low
  swsf_if.master bus, // single-wire line
  input wire logic fast_speed_flag, // fast timing
  input wire logic cmd_valid, // queue a byte operation
  output logic cmd_ready, // queue has room
  input wire logic cmd_read, // 1: 8 read slots, 0: write cmd_data
  input wire logic [7:0] cmd_data, // byte to write, lsb first
  output logic rd_valid, // pulse: byte read
  output logic [7:0] rd_data, // byte read
  output logic id_checked, // pulse: 8th id byte compared
  output logic id_match, // crc8 of 56 bits equals 8th byte
  output logic [15:0] crc16, // running crc over exchanged bytes
  input wire logic crc_clr, // clears crc16 and id check
  output logic busy // byte operation in progress
);
  import swsf_pkg::*;
  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_LOW = 2'b01,
    M_REL = 2'b10,
    M_REC = 2'b11
  } swsf_mst_e;

  swsf_mst_e st_r;
  swsf_cnt_t tmr_r, low_t, msr_t, slot_t, rec_t;
  logic ln_s1_r, ln_r, m_oe_r, is_rd_r, samp_r, pop, q_valid, q_rd, fifo_ready;
  logic [7:0] q_data, sh_r, byte_r, byte_nxt, id_crc_r;
  logic [2:0] bit_r, id_cnt_r;
  logic byte_end;

  assign bus.m_oe = m_oe_r;

  swsf_fifo #(.W(9), .D(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(cmd_valid),
    .in_ready(fifo_ready),
    .in_data({cmd_read, cmd_data}),
    .out_valid(q_valid),
    .out_ready(pop),
    .out_data({q_rd, q_data})
  );

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cmd_ready <= 1'b0;
    end else begin
      // registered copy may lag one cycle; fifo still refuses when full
      cmd_ready <= fifo_ready && !(cmd_valid && cmd_ready);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ln_s1_r <= 1'b1;
      ln_r <= 1'b1;
    end else begin
      ln_s1_r <= bus.line;
      ln_r <= ln_s1_r;
    end
  end

  always_comb begin
    if (is_rd_r) begin
      low_t = pick(fast_speed_flag, RL_STD, RL_OD);
    end else if (sh_r[0]) begin
      low_t = pick(fast_speed_flag, W1L_STD, W1L_OD);
    end else begin
      low_t = pick(fast_speed_flag, W0L_STD, W0L_OD);
    end
    msr_t = pick(fast_speed_flag, MSR_STD, MSR_OD);
    slot_t = pick(fast_speed_flag, SLOT_STD, SLOT_OD);
    rec_t = pick(fast_speed_flag, REC_STD, REC_OD) + swsf_cnt_t'(REC_EXTRA);
    // only this end starts slots, and only from a quiet line
    pop = (st_r == M_IDLE) && ln_r && q_valid;
    byte_end = (st_r == M_REC) && (tmr_r >= rec_t) && (bit_r == LAST_BIT);
    byte_nxt = is_rd_r ? {samp_r, byte_r[7:1]} : byte_r;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= M_IDLE;
      tmr_r <= '0;
      m_oe_r <= 1'b0;
      bit_r <= '0;
      is_rd_r <= 1'b0;
      sh_r <= '0;
      byte_r <= '0;
      samp_r <= 1'b1;
    end else begin
      case (st_r)
        M_IDLE: begin
          if (pop) begin
            st_r <= M_LOW;
            tmr_r <= '0;
            m_oe_r <= 1'b1;
            bit_r <= '0;
            is_rd_r <= q_rd;
            sh_r <= q_data;
            byte_r <= q_rd ? 8'h00 : q_data;
          end
        end
        M_LOW: begin
          tmr_r <= tmr_r + 1'b1;
          if (tmr_r + 1'b1 >= low_t) begin
            m_oe_r <= 1'b0;
            st_r <= M_REL;
          end
        end
        M_REL: begin
          tmr_r <= tmr_r + 1'b1;
          if (is_rd_r && tmr_r == msr_t) begin
            samp_r <= ln_r;
          end
          if (tmr_r + 1'b1 >= slot_t && ln_r) begin
            st_r <= M_REC;
            tmr_r <= '0;
          end
        end
        default: begin
          tmr_r <= tmr_r + 1'b1;
          if (tmr_r >= rec_t) begin
            // recovery counted from slot end with the line seen high, before any new slot
            tmr_r <= '0;
            bit_r <= bit_r + 1'b1;
            sh_r <= {1'b0, sh_r[7:1]};
            if (is_rd_r) begin
              byte_r <= {samp_r, byte_r[7:1]};
            end
            if (bit_r == LAST_BIT) begin
              st_r <= M_IDLE;
            end else begin
              st_r <= M_LOW;
              m_oe_r <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
      rd_data <= '0;
      busy <= 1'b0;
    end else begin
      rd_valid <= byte_end && is_rd_r;
      busy <= (st_r != M_IDLE) && !byte_end;
      if (byte_end && is_rd_r) begin
        rd_data <= byte_nxt;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      crc16 <= '0;
    end else if (crc_clr) begin
      crc16 <= '0;
    end else if (byte_end) begin
      crc16 <= crc16_byte(crc16, byte_nxt);
    end
  end

  // id check: crc8 over 7 read bytes, 8th byte compared as received
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      id_cnt_r <= '0;
      id_crc_r <= '0;
      id_match <= 1'b0;
      id_checked <= 1'b0;
    end else begin
      id_checked <= 1'b0;
      // a check landing with crc_clr still reports; the clear only restarts counting
      if (byte_end && is_rd_r && id_cnt_r == ID_LAST_BYTE) begin
        id_match <= (byte_nxt == id_crc_r);
        id_checked <= 1'b1;
      end else if (crc_clr) begin
        id_match <= 1'b0;
      end
      if (crc_clr) begin
        id_cnt_r <= '0;
        id_crc_r <= '0;
      end else if (byte_end && is_rd_r) begin
        id_cnt_r <= id_cnt_r + 1'b1;
        id_crc_r <= (id_cnt_r == ID_LAST_BYTE) ? '0 : crc8_byte(id_crc_r, byte_nxt);
      end
    end
  end
endmodule

// ---- bench/swsf_asserts.sv ----
module swsf_asserts
  import swsf_pkg::*;
(
  input wire logic clock, // 20 MHz
  input wire logic rst_n, // async, active low
  input wire logic m_oe, // master pulls low
  input wire logic s_oe, // slave pulls low
  input wire logic line, // wired-and level
  input wire logic fast_speed_flag // fast timing
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] pc_r;
  logic [11:0] mc_r;
  logic [11:0] gc_r;
  logic mq_r;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // gap counter saturates so the first slot after reset always passes
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pc_r <= 12'h000;
      mc_r <= 12'h000;
      gc_r <= 12'hfff;
      mq_r <= 1'b0;
    end else begin
      pc_r <= s_oe ? pc_r + 12'h001 : 12'h000;
      mc_r <= m_oe ? mc_r + 12'h001 : 12'h000;
      gc_r <= (m_oe && !mq_r) ? 12'h001 : (gc_r == 12'hfff) ? gc_r : gc_r + 12'h001;
      mq_r <= m_oe;
    end
  end
  sequence s_pull;
    s_oe [*8] ##[1:700] !s_oe;
  endsequence
  AST_S_IN_SLOT: assert property ($rose(s_oe) |-> m_oe)
    else $error("slave pulled outside an open slot");
  AST_S_PULL_TIMED: assert property ($rose(s_oe) |-> s_pull)
    else $error("slave pulldown not released in time");
  AST_S_PULL_LEN: assert property ($fell(s_oe) |-> (fast_speed_flag ?
    (pc_r >= PULL_OD - 12'h010 && pc_r <= PULL_OD) :
    (pc_r >= PULL_STD - 12'h028 && pc_r <= PULL_STD)))
    else $error("slave pulldown length wrong");
  AST_M_LOW_LEN: assert property ($fell(m_oe) |-> (fast_speed_flag ?
    (mc_r == W1L_OD || mc_r == W0L_OD) : (mc_r == W1L_STD || mc_r == W0L_STD)))
    else $error("master low time wrong");
  AST_M_SPACING: assert property ($rose(m_oe) |->
    gc_r >= (fast_speed_flag ? SLOT_OD : SLOT_STD))
    else $error("master slots too close");
  AST_M_OPENS_IDLE: assert property ($rose(m_oe) |-> !s_oe && $past(line))
    else $error("master opened slot on busy line");
  AST_S_FILTERED: assert property ($rose(s_oe) && !fast_speed_flag |-> $past(m_oe, 10))
    else $error("slave answered unfiltered low");
  AST_S_OUTLASTS_M: assert property ($fell(m_oe) && s_oe |-> s_oe [*8])
    else $error("slave released with master");
endmodule

// ---- bench/swsf_bench.sv ----
module swsf_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import swsf_pkg::*;
  localparam logic [55:0] ID = 56'h5e_a1c3_0f77_2b19; // arbitrary test value
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic fast = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic [7:0] cmd_data = 8'h00;
  logic crc_clr = 1'b0;
  logic rd_mode = 1'b0;
  logic tx_load = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic cmd_ready, rd_valid, id_checked, id_match, busy, tx_done, rx_valid, rx2_valid;
  logic [7:0] rd_data, rx_data, rx2_data, rx2_last;
  logic [15:0] m_crc, s_crc;
  logic [63:0] id_code;
  logic last_match;
  logic [7:0] rxq[$];
  logic [7:0] rdq[$];
  int n_chk = 0;
  int n_tx = 0;
  int n_rx2 = 0;
  int fails = 0;
  int checked = 0;
  swsf_if bus ();
  swsf_if bus2 ();
  swsf_master u_swsf_master (.clock(clock), .rst_n(rst_n), .bus(bus),
    .fast_speed_flag(fast), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_read(cmd_read), .cmd_data(cmd_data), .rd_valid(rd_valid), .rd_data(rd_data),
    .id_checked(id_checked), .id_match(id_match), .crc16(m_crc), .crc_clr(crc_clr),
    .busy(busy));
  swsf_slave #(.ID_DATA(ID)) u_swsf_slave (.clock(clock), .rst_n(rst_n), .bus(bus),
    .fast_speed_flag(fast), .rd_mode(rd_mode), .tx_load(tx_load), .tx_data(tx_data),
    .tx_done(tx_done), .rx_valid(rx_valid), .rx_data(rx_data), .crc16(s_crc),
    .crc_clr(crc_clr), .id_code(id_code));
  // second slave faces the bench, which breaks the line rules on purpose
  swsf_slave u_swsf_slave2 (.clock(clock), .rst_n(rst_n), .bus(bus2),
    .fast_speed_flag(fast), .rd_mode(1'b0), .tx_load(tx_load), .tx_data(tx_data),
    .tx_done(), .rx_valid(rx2_valid), .rx_data(rx2_data), .crc16(),
    .crc_clr(crc_clr), .id_code());
  swsf_asserts u_swsf_asserts (.clock(clock), .rst_n(rst_n), .m_oe(bus.m_oe),
    .s_oe(bus.s_oe), .line(bus.line), .fast_speed_flag(fast));
  initial begin
    forever #25 clock = ~clock;
  end
  always @(posedge clock) begin
    if (rx_valid === 1'b1) rxq.push_back(rx_data);
    if (rd_valid === 1'b1) rdq.push_back(rd_data);
    if (tx_done === 1'b1) n_tx++;
    if (rx2_valid === 1'b1) begin
      n_rx2++;
      rx2_last = rx2_data;
    end
    if (id_checked === 1'b1) begin
      n_chk++;
      last_match = id_match;
    end
  end
  function automatic logic [15:0] crc_b(input logic [15:0] c, input logic [7:0] d,
                                        input logic [15:0] p);
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ p) : (c >> 1);
    end
    return c;
  endfunction
  function automatic int lvl(input int w);
    return (w == 0) ? rxq.size() : (w == 1) ? rdq.size() : n_rx2;
  endfunction
  task automatic give_verdict();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] e, input logic [63:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #5;
  endtask
  task automatic wait_for(input int w, input int n);
    for (int i = 0; i < 40000 && lvl(w) < n; i++) tick(1);
    if (lvl(w) < n) begin
      fails++;
      $display("Error wait %0d expected %0d seen %0d", w, n, lvl(w));
      give_verdict();
    end
  endtask
  // refusal shows as cmd_ready low for four cycles in a row
  task automatic push(input logic rd, input logic [7:0] d, output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      ok = (cmd_ready === 1'b1);
      if (!ok) tick(1);
    end
    if (ok) begin
      cmd_valid = 1'b1;
      cmd_read = rd;
      cmd_data = d;
      tick(1);
      cmd_valid = 1'b0;
      tick(1);
    end
  endtask
  task automatic low2(input int n, input int gap);
    bus2.m_oe = 1'b1;
    tick(n);
    bus2.m_oe = 1'b0;
    tick(gap);
  endtask
  task automatic load(input logic [7:0] d);
    tx_data = d;
    tx_load = 1'b1;
    tick(1);
    tx_load = 1'b0;
  endtask
  initial begin
    int n;
    logic ok;
    logic [7:0] b;
    logic [7:0] e2;
    logic [15:0] c;
    logic [63:0] eid;
    logic [3:0] nib;
    nib = 4'h6;
    bus2.m_oe = 1'b0;
    tick(16);
    rst_n = 1'b1;
    tick(2);
    low2(4, 200);
    for (int k = 0; k < 4; k++) begin
      low2(nib[k] ? W1L_STD : W0L_STD, nib[k] ? PULL_STD - W1L_STD + 5 : 8);
      low2(20, 5);
      low2(W1L_STD, 1300);
      e2[2*k] = nib[k];
      e2[2*k+1] = 1'b1;
    end
    wait_for(2, 1);
    chk("rx2_data", e2, rx2_last);
    push(1'b0, 8'ha5, ok);
    wait_for(0, 1);
    chk("rx_data", 8'ha5, rxq[0]);
    c = crc_b(16'h0000, 8'ha5, CRC16_POLY_REFL);
    rd_mode = 1'b1;
    load(8'h3c);
    push(1'b1, 8'h00, ok);
    wait_for(1, 1);
    chk("rd_data", 8'h3c, rdq[0]);
    chk("tx_done", 1, n_tx);
    c = crc_b(c, 8'h3c, CRC16_POLY_REFL);
    rd_mode = 1'b0;
    fast = 1'b1;
    tick(200);
    // two-cycle dips must not open slots at fast speed
    for (int k = 0; k < 8; k++) begin
      low2(2, 10);
      low2(e2[k] ? W0L_OD : W1L_OD, 100);
    end
    wait_for(2, 2);
    chk("rx2_fast", 8'(~e2), rx2_last);
    n = 0;
    ok = 1'b1;
    while (ok && n < 12) begin
      push(1'b0, 8'h25 * n[7:0] + 8'h01, ok);
      if (ok) n++;
    end
    chk("fill_count", 1, n >= 8 && n < 12);
    chk("busy", 1, busy);
    wait_for(0, n + 1);
    for (int k = 0; k < n; k++) begin
      b = 8'h25 * k[7:0] + 8'h01;
      chk("rx_fast", b, rxq[k+1]);
      c = crc_b(c, b, CRC16_POLY_REFL);
    end
    tick(300);
    chk("busy_idle", 0, busy);
    chk("m_crc16", c, m_crc);
    chk("s_crc16", c, s_crc);
    c = 16'h0000;
    for (int k = 0; k < 7; k++) c = crc_b(c, ID[8*k +: 8], {8'h00, CRC8_POLY_REFL});
    eid = {c[7:0], ID};
    chk("id_code", eid, id_code);
    rd_mode = 1'b1;
    for (int p = 0; p < 2; p++) begin
      crc_clr = 1'b1;
      tick(1);
      crc_clr = 1'b0;
      c = 16'h0000;
      for (int k = 0; k < 8; k++) begin
        b = eid[8*k +: 8] ^ ((p == 1 && k == 3) ? 8'h10 : 8'h00);
        load(b);
        push(1'b1, 8'h00, ok);
        wait_for(1, 2 + 8 * p + k);
        chk("id_byte", b, rdq[1 + 8 * p + k]);
        c = crc_b(c, b, CRC16_POLY_REFL);
      end
      tick(20);
      chk("id_checks", p + 1, n_chk);
      chk("id_match", p == 0, last_match);
      chk("m_crc16_id", c, m_crc);
      chk("s_crc16_id", c, s_crc);
    end
    give_verdict();
  end
endmodule
